// *** verif/eos_host.sv ***
// Remote controller model that issues status commands one at a time.
// Assumes the block answers a query in the cycle after it takes it.
`timescale 1ns/1ps
`default_nettype none
module eos_host (
   // Clock and answer
   input  wire logic        core_clk_i,
   input  wire logic        rsp_valid_i,
   input  wire logic [15:0] rsp_data_i,
   // Command
   output var  logic        cmd_valid_o,
   output var  logic [3:0]  cmd_code_o,
   output var  logic [15:0] cmd_data_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 4'h0;
      cmd_data_o  = 16'h0000;
   end
   // Commands held a cycle, write data in range.
   task automatic issue(input logic [3:0] c, input logic [15:0] d,
                        output logic got, output logic [15:0] rd);
      @(negedge core_clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o  = c;
      cmd_data_o  = d & 16'h7FFF;
      @(negedge core_clk_i);
      got = rsp_valid_i;
      rd  = rsp_data_i;
      cmd_valid_o = 1'b0;
      // Released lines show a changed pattern, not the stale value.
      cmd_code_o  = ~c;
      cmd_data_o  = ~d;
   endtask
endmodule // eos_host
`default_nettype wire

// *** verif/eos_status_checker.sv ***
// Assertions on the ports of the status block.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "eos_regs.vh"
module eos_status_checker #(
   parameter DATA_W = 16
) (
   // Clock and reset
   input wire logic                  core_clk_i,
   input wire logic                  sys_rst_i,
   // Command port
   input wire logic                  cmd_valid_i,
   input wire logic [`EOS_CMD_W-1:0] cmd_code_i,
   input wire logic                  rsp_valid_o,
   input wire logic [DATA_W-1:0]     rsp_data_o,
   // Event sources
   input wire logic                  opc_request_i,
   input wire logic                  ops_idle_i,
   input wire logic                  query_err_i,
   input wire logic                  device_err_i,
   input wire logic                  exec_err_i,
   input wire logic                  command_err_i,
   // Watched conditions and summary
   input wire logic                  term_a_active_i,
   input wire logic                  hazard_voltage_flag_i,
   input wire logic                  esb_summary_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic is_q = cmd_valid_i && (cmd_code_i inside {`EOS_CMD_ESE_QRY,
      `EOS_CMD_ESR_QRY, `EOS_CMD_OPERATION_STATUS_EVT_QRY, `EOS_CMD_OPERATION_STATUS_CON_QRY,
      `EOS_CMD_OPERATION_STATUS_ENA_QRY, `EOS_CMD_OPERATION_STATUS_PTR_QRY, `EOS_CMD_OPERATION_STATUS_NTR_QRY});
   wire logic quiet = !(query_err_i || device_err_i || exec_err_i || command_err_i);

   a_query_answer: assert property (is_q |=> rsp_valid_o)
      else $error("query not answered");
   a_set_silent: assert property (!is_q |=> !rsp_valid_o)
      else $error("answer without query");
   a_qye_flag: assert property (query_err_i |=> esb_summary_o)
      else $error("query error not summarised");
   a_dde_flag: assert property (device_err_i |=> esb_summary_o)
      else $error("device error not summarised");
   a_exe_flag: assert property (exec_err_i |=> esb_summary_o)
      else $error("execution error not summarised");
   a_cme_flag: assert property (command_err_i |=> esb_summary_o)
      else $error("command error not summarised");
   a_opc_flag: assert property (opc_request_i && ops_idle_i |=> esb_summary_o)
      else $error("operation complete not set");
   a_esr_clear: assert property (cmd_valid_i && cmd_code_i == `EOS_CMD_ESR_QRY
      && quiet && !ops_idle_i |=> !esb_summary_o)
      else $error("event summary after read");
   a_esr_unused: assert property (rsp_valid_o && $past(cmd_code_i) == `EOS_CMD_ESR_QRY
      |-> (rsp_data_o & 16'hFF42) == 16'h0000)
      else $error("unused event bit set");
   a_cond_bits: assert property (cmd_valid_i && cmd_code_i == `EOS_CMD_OPERATION_STATUS_CON_QRY
      |=> rsp_data_o[0] == $past(term_a_active_i, 2)
      && rsp_data_o[3] == $past(hazard_voltage_flag_i, 2)
      && rsp_data_o[4] == 1'b0 && rsp_data_o[7] == 1'b0 && rsp_data_o[15] == 1'b0)
      else $error("condition answer wrong");
   a_rsp_hold: assert property (!rsp_valid_o |-> $stable(rsp_data_o))
      else $error("answer data moved");
endmodule // eos_status_checker
bind eos_status eos_status_checker #(.DATA_W(DATA_W)) eos_status_checker_i (
   .core_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_code_i, .rsp_valid_o, .rsp_data_o,
   .opc_request_i, .ops_idle_i, .query_err_i, .device_err_i, .exec_err_i,
   .command_err_i, .term_a_active_i, .hazard_voltage_flag_i, .esb_summary_o);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the status block with a reference model.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "eos_regs.vh"
module tb_top;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid_i, rsp_valid_o, esb_summary_o, operation_status_summary_o, got;
   logic [3:0] cmd_code_i;
   logic [15:0] cmd_data_i, rsp_data_o, rd;
   logic opc_request_i = 1'b0;
   logic ops_idle_i = 1'b0;
   logic [3:0] errs = 4'h0;
   logic [15:0] conds = 16'h0000;
   logic [15:0] ev_m, cnd_m, fm[3];
   logic [3:0] sc[3] = '{`EOS_CMD_OPERATION_STATUS_ENA_SET, `EOS_CMD_OPERATION_STATUS_PTR_SET, `EOS_CMD_OPERATION_STATUS_NTR_SET};
   logic [31:0] rng = 32'hA554;
   logic [7:0] ese;
   int n_fail = 0;
   int tests_run = 0;
   always #5 core_clk_i = ~core_clk_i;
   eos_host eos_host_i (.core_clk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
      .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i));
   eos_status eos_status_i (.core_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i,
      .rsp_valid_o, .rsp_data_o, .opc_request_i, .ops_idle_i, .query_err_i(errs[0]),
      .device_err_i(errs[1]), .exec_err_i(errs[2]), .command_err_i(errs[3]),
      .term_a_active_i(conds[0]), .term_b_active_i(conds[1]), .eut_line_active_i(conds[2]),
      .hazard_voltage_flag_i(conds[3]), .trig_wait_i(conds[5]), .test_hold_i(conds[6]),
      .judge_pass_i(conds[8]), .judge_fail_i(conds[9]), .test_running_i(conds[10]),
      .stop_key_i(conds[11]), .test_wait_i(conds[12]), .interval_i(conds[13]),
      .prog_test_i(conds[14]), .esb_summary_o, .operation_status_summary_o);
   function automatic logic [31:0] nxt(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic q(input logic [3:0] c, input logic [15:0] e, input string n);
      eos_host_i.issue(c, 16'h0000, got, rd);
      check({n, "_valid"}, {15'h0000, got}, 16'h0001);
      check(n, rd, e);
   endtask
   task automatic w(input logic [3:0] c, input logic [15:0] d);
      eos_host_i.issue(c, d, got, rd);
      check("set_silent", {15'h0000, got}, 16'h0000);
   endtask
   // Conditions change at a falling edge; the model accumulates filtered edges.
   task automatic setc(input logic [15:0] nc);
      @(negedge core_clk_i);
      conds = nc;
      ev_m = ev_m | (((nc & ~cnd_m & fm[1]) | (~nc & cnd_m & fm[2])) & 16'h7F6F);
      cnd_m = nc & 16'h7F6F;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20us;
      n_fail++;
      give_verdict();
   end
   initial begin
      ev_m = 16'h0000;
      cnd_m = 16'h0000;
      repeat (12) @(posedge core_clk_i);
      @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      q(`EOS_CMD_ESR_QRY, 16'h0080, "esr_pon");
      q(`EOS_CMD_ESR_QRY, 16'h0000, "esr_clr");
      q(`EOS_CMD_OPERATION_STATUS_PTR_QRY, 16'h7FFF, "ptr_rst");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         @(negedge core_clk_i);
         errs[i] = 1'b1;
         @(negedge core_clk_i);
         errs = 4'h0;
         q(`EOS_CMD_ESR_QRY, 16'h0004 << i, "esr_err");
      end
      @(negedge core_clk_i);
      opc_request_i = 1'b1;
      @(negedge core_clk_i);
      opc_request_i = 1'b0;
      q(`EOS_CMD_ESR_QRY, 16'h0000, "opc_busy");
      ops_idle_i = 1'b1;
      @(negedge core_clk_i);
      ops_idle_i = 1'b0;
      q(`EOS_CMD_ESR_QRY, 16'h0001, "opc_done");
      @(negedge core_clk_i);
      opc_request_i = 1'b1;
      ops_idle_i = 1'b1;
      @(negedge core_clk_i);
      opc_request_i = 1'b0;
      ops_idle_i = 1'b0;
      q(`EOS_CMD_ESR_QRY, 16'h0001, "opc_same");
      rng = nxt(rng);
      ese = rng[7:0];
      w(`EOS_CMD_ESE_SET, {8'h00, ese});
      q(`EOS_CMD_ESE_QRY, {8'h00, ese}, "ese");
      $display("test events done");
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 3; k++) begin
            rng = nxt(rng);
            fm[k] = rng[15:0] & 16'h7FFF;
            w(sc[k], fm[k]);
            q(sc[k] + 4'h1, fm[k], "filter");
         end
         for (int i = 0; i < 24; i++) begin
            rng = nxt(rng);
            setc(rng[15:0]);
            q(`EOS_CMD_OPERATION_STATUS_CON_QRY, cnd_m, "cond");
            check("operation_status_sum", {15'h0000, operation_status_summary_o}, {15'h0000, |(ev_m & fm[0])});
            if (i % 4 == 3) begin
               q(`EOS_CMD_OPERATION_STATUS_EVT_QRY, ev_m, "event");
               ev_m = 16'h0000;
               q(`EOS_CMD_OPERATION_STATUS_EVT_QRY, 16'h0000, "event_clr");
            end
         end
      end
      $display("test operation done");
      w(`EOS_CMD_PRESET, 16'h0000);
      q(`EOS_CMD_OPERATION_STATUS_ENA_QRY, 16'h0000, "ena_pre");
      q(`EOS_CMD_OPERATION_STATUS_PTR_QRY, 16'h7FFF, "ptr_pre");
      q(`EOS_CMD_OPERATION_STATUS_NTR_QRY, 16'h0000, "ntr_pre");
      q(`EOS_CMD_ESE_QRY, {8'h00, ese}, "ese_kept");
      w(4'hE, 16'h1234);
      w(4'h0, 16'h4321);
      q(`EOS_CMD_OPERATION_STATUS_ENA_QRY, 16'h0000, "ena_unk");
      $display("test preset done");
      fm[0] = 16'h0000;
      fm[1] = 16'h7FFF;
      fm[2] = 16'h0000;
      setc(16'h0000);
      setc(16'h7F6F);
      errs[1] = 1'b1;
      @(negedge core_clk_i);
      errs = 4'h0;
      check("esb_set", {15'h0000, esb_summary_o}, 16'h0001);
      w(`EOS_CMD_CLEAR, 16'h0000);
      check("esb_clr", {15'h0000, esb_summary_o}, 16'h0000);
      q(`EOS_CMD_OPERATION_STATUS_EVT_QRY, 16'h0000, "event_cleared");
      q(`EOS_CMD_ESR_QRY, 16'h0000, "esr_cleared");
      q(`EOS_CMD_OPERATION_STATUS_CON_QRY, 16'h7F6F, "cond_kept");
      ev_m = 16'h0000;
      $display("test clear done");
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire

// *** verilog/eos_regs.vh ***
// Constants for the event and operation status block: command codes,
// bit positions and reset or preset values.
// Assumes it is included by its bare name from design and bench files.
`ifndef EOS_REGS_VH
`define EOS_REGS_VH

// ----------------------------------------------------------------------
// Command codes on the status command port
// ----------------------------------------------------------------------
`define EOS_CMD_W            4
`define EOS_CMD_ESE_SET      4'h1
`define EOS_CMD_ESE_QRY      4'h2
`define EOS_CMD_ESR_QRY      4'h3
`define EOS_CMD_OPERATION_STATUS_EVT_QRY 4'h4
`define EOS_CMD_OPERATION_STATUS_CON_QRY 4'h5
`define EOS_CMD_OPERATION_STATUS_ENA_SET 4'h6
`define EOS_CMD_OPERATION_STATUS_ENA_QRY 4'h7
`define EOS_CMD_OPERATION_STATUS_PTR_SET 4'h8
`define EOS_CMD_OPERATION_STATUS_PTR_QRY 4'h9
`define EOS_CMD_OPERATION_STATUS_NTR_SET 4'hA
`define EOS_CMD_OPERATION_STATUS_NTR_QRY 4'hB
`define EOS_CMD_PRESET       4'hC
`define EOS_CMD_CLEAR        4'hD

// ----------------------------------------------------------------------
// Standard event status bit positions
// ----------------------------------------------------------------------
`define EOS_ESR_OPC 0
`define EOS_ESR_QYE 2
`define EOS_ESR_DDE 3
`define EOS_ESR_EXE 4
`define EOS_ESR_CME 5
`define EOS_ESR_PON 7

// ----------------------------------------------------------------------
// Operation status bit positions
// ----------------------------------------------------------------------
`define EOS_OP_TERM_A  0
`define EOS_OP_TERM_B  1
`define EOS_OP_EUT     2
`define EOS_OP_HAZARD  3
`define EOS_OP_TRIG    5
`define EOS_OP_HOLD    6
`define EOS_OP_PASS    8
`define EOS_OP_FAIL    9
`define EOS_OP_RUN     10
`define EOS_OP_STOP    11
`define EOS_OP_WAIT    12
`define EOS_OP_INTVL   13
`define EOS_OP_PROG    14

// ----------------------------------------------------------------------
// Reset, preset and mask values
// ----------------------------------------------------------------------
`define EOS_ESR_RST      8'h80
`define EOS_ESR_USED     8'hBD
`define EOS_OP_USED      16'h7F6F
`define EOS_WR_MASK      16'h7FFF
`define EOS_ENA_PRESET   16'h0000
`define EOS_PTR_PRESET   16'h7FFF
`define EOS_NTR_PRESET   16'h0000

`endif

// *** verilog/eos_status.v ***
// Standard event status and operation status registers of a leakage
// current tester, reached through a decoded status command port.
// Assumes the command parser delivers one command per valid cycle and
// that all event and condition inputs are synchronous to core_clk_i.
// The status byte logic outside merges the two summary bits with its own.
`timescale 1ns/1ps
`default_nettype none

`include "eos_regs.vh"

// Function
// - Set operation-complete after request and idle
// - Set query error on empty read
// - Set device error on instrument fault
// - Set execution error on bad parameter
// - Set command error on syntax fault
// - Set power-on bit at power up
// - Event register reached by common commands
// - Operation register sixteen bits wide
// - Bits 0-2 follow terminals and line
// - Bit 3 shows hazard voltage
// - Bit 5 shows trigger wait
// - Bit 6 shows hold state
// - Bit 11 shows stop key
// - Bits 12-13 show wait, interval
// - Bit 14 shows program test
// - Event read returns value, then clears
// - Condition read leaves contents unchanged
// - Enable mask stored and returned
// - Positive filter stored and returned
// - Negative filter stored and returned
// - Event on filtered rise or fall
// - Operation summary from enabled events
// - Event summary from any event bit
// - Preset restores operation masks and filters; event enable mask kept
module eos_status #(
   parameter DATA_W = 16
) (
   // Clock and reset
   input  wire                  core_clk_i,
   input  wire                  sys_rst_i,
   // Status command port
   input  wire                  cmd_valid_i,
   input  wire [`EOS_CMD_W-1:0] cmd_code_i,
   input  wire [DATA_W-1:0]     cmd_data_i,
   output reg                   rsp_valid_o,
   output reg  [DATA_W-1:0]     rsp_data_o,
   // Standard event sources
   input  wire                  opc_request_i,
   input  wire                  ops_idle_i,
   input  wire                  query_err_i,
   input  wire                  device_err_i,
   input  wire                  exec_err_i,
   input  wire                  command_err_i,
   // Operation conditions
   input  wire                  term_a_active_i,
   input  wire                  term_b_active_i,
   input  wire                  eut_line_active_i,
   input  wire                  hazard_voltage_flag_i,
   input  wire                  trig_wait_i,
   input  wire                  test_hold_i,
   input  wire                  judge_pass_i,
   input  wire                  judge_fail_i,
   input  wire                  test_running_i,
   input  wire                  stop_key_i,
   input  wire                  test_wait_i,
   input  wire                  interval_i,
   input  wire                  prog_test_i,
   // Status byte summary bits
   output reg                   esb_summary_o,
   output reg                   operation_status_summary_o
);

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   // True when the command code names a query that produces a response.
   function is_query;
      input [`EOS_CMD_W-1:0] code;
      begin
         case (code)
            `EOS_CMD_ESE_QRY,
            `EOS_CMD_ESR_QRY,
            `EOS_CMD_OPERATION_STATUS_EVT_QRY,
            `EOS_CMD_OPERATION_STATUS_CON_QRY,
            `EOS_CMD_OPERATION_STATUS_ENA_QRY,
            `EOS_CMD_OPERATION_STATUS_PTR_QRY,
            `EOS_CMD_OPERATION_STATUS_NTR_QRY: is_query = 1'b1;
            default:               is_query = 1'b0;
         endcase
      end
   endfunction

   // True when this cycle carries the given command.
   function cmd_is;
      input                  valid;
      input [`EOS_CMD_W-1:0] code;
      input [`EOS_CMD_W-1:0] want;
      begin
         cmd_is = valid & (code == want);
      end
   endfunction

   // Writes accept 0 to 32767; bit 15 never stores.
   function [15:0] clip15;
      input [DATA_W-1:0] value;
      begin
         clip15 = value[15:0] & `EOS_WR_MASK;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   // Standard event status, its enable mask and the completion flag.
   reg  [7:0]  standard_event_status;
   reg  [7:0]  ese;
   reg         opc_pending;
   // Operation event register, enable mask and transition filters.
   reg  [15:0] operation_status_event;
   reg  [15:0] operation_status_enable;
   reg  [15:0] operation_status_ptr;
   reg  [15:0] operation_status_ntr;

   wire [15:0] operation_status_cond;
   wire [15:0] operation_status_event_set;
   reg  [15:0] cond_vector;

   // Next-state values built by the combinational processes.
   reg  [7:0]  next_esr;
   reg  [7:0]  esr_set;
   reg         next_opc_pending;
   reg  [15:0] next_operation_status_event;
   reg  [DATA_W-1:0] next_rsp_data;

   // Decoded command strobes.
   wire        rd_esr;
   wire        rd_operation_status_event;
   wire        do_preset;
   wire        do_clear;
   wire        take_query;

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // Decode stays combinational; the answer register gives the one-cycle
   // delay, so a query is answered on the edge that takes it and is seen in the cycle after.
   // common command decode
   assign rd_esr        = cmd_is(cmd_valid_i, cmd_code_i, `EOS_CMD_ESR_QRY);
   assign rd_operation_status_event = cmd_is(cmd_valid_i, cmd_code_i, `EOS_CMD_OPERATION_STATUS_EVT_QRY);
   assign do_preset     = cmd_is(cmd_valid_i, cmd_code_i, `EOS_CMD_PRESET);
   assign do_clear      = cmd_is(cmd_valid_i, cmd_code_i, `EOS_CMD_CLEAR);
   assign take_query    = cmd_valid_i & is_query(cmd_code_i);

   // ----------------------------------------------------------------------
   // Operation condition vector
   // ----------------------------------------------------------------------
   // Bits 4, 7 and 15 have no source and read zero; the mask at the sampler
   // input keeps them clear even if one is wired by mistake later.
   // sixteen-bit condition word
   always @* begin
      cond_vector = 16'h0000;
      cond_vector[`EOS_OP_TERM_A] = term_a_active_i;
      cond_vector[`EOS_OP_TERM_B] = term_b_active_i;
      cond_vector[`EOS_OP_EUT]    = eut_line_active_i;
      cond_vector[`EOS_OP_HAZARD] = hazard_voltage_flag_i;
      cond_vector[`EOS_OP_TRIG]   = trig_wait_i;
      cond_vector[`EOS_OP_HOLD]   = test_hold_i;
      cond_vector[`EOS_OP_PASS]   = judge_pass_i;
      cond_vector[`EOS_OP_FAIL]   = judge_fail_i;
      cond_vector[`EOS_OP_RUN]    = test_running_i;
      cond_vector[`EOS_OP_STOP]   = stop_key_i;
      cond_vector[`EOS_OP_WAIT]   = test_wait_i;
      cond_vector[`EOS_OP_INTVL]  = interval_i;
      cond_vector[`EOS_OP_PROG]   = prog_test_i;
   end

   // The sampler registers the condition word; its event output is
   // combinational and is folded into the event register below.
   eos_transition #(
      .WIDTH (16)
   ) u_transition (
      .core_clk_i  (core_clk_i),
      .sys_rst_i   (sys_rst_i),
      .cond_in_i   (cond_vector & `EOS_OP_USED),
      .ptr_i       (operation_status_ptr),
      .ntr_i       (operation_status_ntr),
      .cond_o      (operation_status_cond),
      .event_set_o (operation_status_event_set)
   );

   // ----------------------------------------------------------------------
   // Standard event status next state
   // ----------------------------------------------------------------------
   // A new event landing on the same edge as a read or a clear survives:
   // the read returns the old value, and the set is kept for the next read.
   // The pending flag remembers a completion request while operations are
   // still running and drops on the edge that sets the bit.
   always @* begin
      esr_set = 8'h00;
      next_opc_pending = opc_pending | opc_request_i;
      if ((opc_pending | opc_request_i) & ops_idle_i) begin
         esr_set[`EOS_ESR_OPC] = 1'b1;
         next_opc_pending = 1'b0;
      end
      esr_set[`EOS_ESR_QYE] = query_err_i;
      esr_set[`EOS_ESR_DDE] = device_err_i;
      esr_set[`EOS_ESR_EXE] = exec_err_i;
      esr_set[`EOS_ESR_CME] = command_err_i;
      if (rd_esr | do_clear) begin
         next_esr = esr_set;
      end else begin
         next_esr = standard_event_status | esr_set;
      end
      next_esr = next_esr & `EOS_ESR_USED;
   end

   // ----------------------------------------------------------------------
   // Operation event next state
   // ----------------------------------------------------------------------
   // A poll and a new transition on the same edge keep the transition, so
   // no edge is lost between two polls.
   always @* begin
      if (rd_operation_status_event | do_clear) begin
         next_operation_status_event = operation_status_event_set;
      end else begin
         next_operation_status_event = operation_status_event | operation_status_event_set;
      end
   end

   // ----------------------------------------------------------------------
   // Response mux
   // ----------------------------------------------------------------------
   // Codes without an answer select zero; that value is never loaded.
   always @* begin
      next_rsp_data = {DATA_W{1'b0}};
      case (cmd_code_i)
         `EOS_CMD_ESE_QRY:      next_rsp_data[7:0] = ese;
         `EOS_CMD_ESR_QRY:      next_rsp_data[7:0] = standard_event_status;
         `EOS_CMD_OPERATION_STATUS_EVT_QRY: next_rsp_data[15:0] = operation_status_event;
         `EOS_CMD_OPERATION_STATUS_CON_QRY: next_rsp_data[15:0] = operation_status_cond;
         `EOS_CMD_OPERATION_STATUS_ENA_QRY: next_rsp_data[15:0] = operation_status_enable;
         `EOS_CMD_OPERATION_STATUS_PTR_QRY: next_rsp_data[15:0] = operation_status_ptr;
         `EOS_CMD_OPERATION_STATUS_NTR_QRY: next_rsp_data[15:0] = operation_status_ntr;
         default:               next_rsp_data = {DATA_W{1'b0}};
      endcase
   end

   // ----------------------------------------------------------------------
   // Event registers
   // ----------------------------------------------------------------------
   // Reset loads the power-on bit, so the first read after power-up reports it.
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         standard_event_status         <= `EOS_ESR_RST;
         opc_pending <= 1'b0;
         operation_status_event  <= 16'h0000;
      end else begin
         standard_event_status         <= next_esr;
         opc_pending <= next_opc_pending;
         operation_status_event  <= next_operation_status_event;
      end
   end

   // ----------------------------------------------------------------------
   // Masks and filters
   // ----------------------------------------------------------------------
   // The event enable mask is not touched by preset; only the operation
   // masks and filters return to their defaults.
   // Bit 15 of a written operation mask or filter is dropped rather than refused, so an
   // out-of-range value leaves its low fifteen bits stored; the event enable mask keeps bits 7-0.
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ese         <= 8'h00;
         operation_status_enable <= `EOS_ENA_PRESET;
         operation_status_ptr    <= `EOS_PTR_PRESET;
         operation_status_ntr    <= `EOS_NTR_PRESET;
      end else if (do_preset) begin
         operation_status_enable <= `EOS_ENA_PRESET;
         operation_status_ptr    <= `EOS_PTR_PRESET;
         operation_status_ntr    <= `EOS_NTR_PRESET;
      end else if (cmd_valid_i) begin
         case (cmd_code_i)
            `EOS_CMD_ESE_SET:      ese <= cmd_data_i[7:0];
            `EOS_CMD_OPERATION_STATUS_ENA_SET: operation_status_enable <= clip15(cmd_data_i);
            `EOS_CMD_OPERATION_STATUS_PTR_SET: operation_status_ptr <= clip15(cmd_data_i);
            `EOS_CMD_OPERATION_STATUS_NTR_SET: operation_status_ntr <= clip15(cmd_data_i);
            default:               ese <= ese;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Responses and summary outputs
   // ----------------------------------------------------------------------
   // The answer register loads only on a query, so the last answer stays
   // readable; both summaries use next-state values to move with their event.
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rsp_valid_o    <= 1'b0;
         rsp_data_o     <= {DATA_W{1'b0}};
         esb_summary_o  <= 1'b0;
         operation_status_summary_o <= 1'b0;
      end else begin
         rsp_valid_o <= take_query;
         if (take_query) begin
            rsp_data_o <= next_rsp_data;
         end
         esb_summary_o  <= |next_esr;
         operation_status_summary_o <= |(next_operation_status_event & operation_status_enable);
      end
   end

endmodule // eos_status

`default_nettype wire

// *** verilog/eos_transition.v ***
// Condition sampler and transition filter for the operation register.
// Assumes the condition inputs are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module eos_transition #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input  wire             core_clk_i,
   input  wire             sys_rst_i,
   // Condition and filters
   input  wire [WIDTH-1:0] cond_in_i,
   input  wire [WIDTH-1:0] ptr_i,
   input  wire [WIDTH-1:0] ntr_i,
   // Results
   output reg  [WIDTH-1:0] cond_o,
   output wire [WIDTH-1:0] event_set_o
);

   // ----------------------------------------------------------------------
   // Condition register
   // ----------------------------------------------------------------------
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cond_o <= {WIDTH{1'b0}};
      end else begin
         cond_o <= cond_in_i;
      end
   end

   // ----------------------------------------------------------------------
   // Edge filter
   // ----------------------------------------------------------------------
   // rise and fall filtering
   // The event fires on the edge at which the condition register takes the
   // new value, so one change that passes its filter yields exactly one event set.
   assign event_set_o = (cond_in_i & ~cond_o & ptr_i) | (~cond_in_i & cond_o & ntr_i);

endmodule // eos_transition

`default_nettype wire
